// *** hw/adm_mode_regs.sv ***
// mode-control register bank with control word decode
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_mode_regs #(
   parameter logic [4:0] CHIP_ID = 5'h00 // arbitrary value
) (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic word_valid_in,
   input wire logic [15:0] word_in,
   input wire logic frame_tick_in,
   input wire logic mute_req_in,
   input wire logic left_zero_det_in,
   input wire logic right_zero_det_in,
   output logic [7:0] read_data_out,
   output logic read_valid_out,
   output logic [1:0] atten_step_rate_out,
   output logic output_disable_out,
   output logic bypass_stereo_select_out,
   output logic rolloff_select_out,
   output logic zero_hold_mute_en_out,
   output logic soft_reset_out,
   output logic one_bit_stream_mode_out,
   output logic filter_bypass_out,
   output logic mono_out,
   output logic mono_channel_pick_out,
   output adm_pkg::adm_osr_t modulator_rate_out,
   output logic stream_bit_clock_sel_out,
   output logic [1:0] stream_zero_pattern_out,
   output logic pcm_zero_flag_en_out,
   output logic left_zero_pin_out,
   output logic right_zero_pin_out,
   output logic left_data_from_zero_pin_out,
   output logic bipolar_zero_level_out,
   output logic [7:0] soft_mute_level_out
);
   import adm_pkg::*;
   logic [7:0] ofc_q, ofc_d, mda_q, mda_d, zfe_q, zfe_d;
   logic soft_reset_q, soft_reset_d;
   logic [7:0] rd_q, rd_d;
   logic rv_q, rv_d;
   logic [1:0] zf_q, zf_d;
   logic bpz_q, bpz_d;
   logic is_wr, is_rd, zf_on, zero_mute, step_en, ramp_muted;
   logic [6:0] addr;
   logic [7:0] wdat, ramp_lvl;

   assign is_wr = word_valid_in && !word_in[`ADM_WORD_DIR_BIT];
   assign is_rd = word_valid_in && word_in[`ADM_WORD_DIR_BIT];
   assign addr = word_in[`ADM_ADDR_HI:`ADM_ADDR_LO];
   assign wdat = word_in[7:0];

   always_comb begin
      ofc_d = ofc_q;
      mda_d = mda_q;
      zfe_d = zfe_q;
      soft_reset_d = 1'b0;
      if (is_wr) begin
         case (addr)
            `ADM_OFS_OUT_FILT: ofc_d = wdat & `ADM_OUT_FILT_MASK;
            `ADM_OFS_MODE_A: begin
               mda_d = wdat & `ADM_MODE_A_MASK;
               soft_reset_d = wdat[`ADM_MAB_SOFT_RESET];
            end
            `ADM_OFS_ZF_EN: zfe_d = wdat & `ADM_ZF_EN_MASK;
            default: ;
         endcase
      end
      if (soft_reset_q) begin
         ofc_d = `ADM_RST_OUT_FILT;
         mda_d = `ADM_RST_MODE_A;
         zfe_d = `ADM_RST_ZF_EN;
      end
   end

   // readback; soft reset bit is write only
   always_comb begin
      rd_d = rd_q;
      rv_d = is_rd;
      if (is_rd) begin
         case (addr)
            `ADM_OFS_OUT_FILT: rd_d = ofc_q;
            `ADM_OFS_MODE_A: rd_d = {2'h0, mda_q[5:0]};
            `ADM_OFS_ZF_EN: rd_d = zfe_q;
            `ADM_OFS_ZF_STAT: rd_d = {6'h00, zf_q};
            `ADM_OFS_DEV_ID: rd_d = {3'h0, CHIP_ID};
            default: rd_d = 8'h00;
         endcase
      end
   end

   // zero flag gating per mode
   always_comb begin
      if (mda_q[`ADM_MAB_STREAM]) begin
         zf_on = zfe_q[`ADM_ZEB_DZ_HI:`ADM_ZEB_DZ_LO] != 2'h0;
      end else begin
         zf_on = zfe_q[`ADM_ZEB_PCM_ZERO_FLAG_EN];
      end
      zf_d = zf_on ? {right_zero_det_in, left_zero_det_in} : 2'h0;
      // zero pins carry data in stereo bypass
      if (mda_q[`ADM_MAB_BYPASS] && ofc_q[`ADM_OFB_BYPASS_STEREO_SELECT]) begin
         zf_d = 2'h0;
      end
   end

   assign zero_mute = ofc_q[`ADM_OFB_ZERO_HOLD_MUTE_EN] && !mda_q[`ADM_MAB_STREAM]
      && left_zero_det_in && right_zero_det_in;

   always_comb begin
      bpz_d = ofc_q[`ADM_OFB_OPE] || zero_mute || ramp_muted;
   end

   adm_step_div u_div (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .frame_tick_in(frame_tick_in),
      .atten_step_rate_in(ofc_q[`ADM_OFB_ATS_HI:`ADM_OFB_ATS_LO]),
      .step_en_out(step_en)
   );

   adm_mute_ramp #(.STEPS(`ADM_RAMP_STEPS)) u_ramp (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .clear_in(soft_reset_q),
      .mute_req_in(mute_req_in),
      .step_en_in(step_en),
      .level_out(ramp_lvl),
      .muted_out(ramp_muted)
   );

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ofc_q <= `ADM_RST_OUT_FILT;
         mda_q <= `ADM_RST_MODE_A;
         zfe_q <= `ADM_RST_ZF_EN;
         soft_reset_q <= 1'b0;
         rd_q <= 8'h00;
         rv_q <= 1'b0;
         zf_q <= 2'h0;
         bpz_q <= 1'b0;
         soft_mute_level_out <= 8'hFF;
      end else begin
         ofc_q <= ofc_d;
         mda_q <= mda_d;
         zfe_q <= zfe_d;
         soft_reset_q <= soft_reset_d;
         rd_q <= rd_d;
         rv_q <= rv_d;
         zf_q <= zf_d;
         bpz_q <= bpz_d;
         soft_mute_level_out <= ramp_lvl;
      end
   end

   assign read_data_out = rd_q;
   assign read_valid_out = rv_q;
   assign soft_reset_out = soft_reset_q;
   assign atten_step_rate_out = ofc_q[`ADM_OFB_ATS_HI:`ADM_OFB_ATS_LO];
   assign output_disable_out = ofc_q[`ADM_OFB_OPE];
   assign bypass_stereo_select_out = ofc_q[`ADM_OFB_BYPASS_STEREO_SELECT];
   assign rolloff_select_out = ofc_q[`ADM_OFB_FLT];
   assign zero_hold_mute_en_out = ofc_q[`ADM_OFB_ZERO_HOLD_MUTE_EN];
   assign one_bit_stream_mode_out = mda_q[`ADM_MAB_STREAM];
   assign filter_bypass_out = mda_q[`ADM_MAB_BYPASS];
   assign mono_out = mda_q[`ADM_MAB_MONO];
   assign mono_channel_pick_out = mda_q[`ADM_MAB_MONO] &&
      mda_q[`ADM_MAB_MONO_CHANNEL_PICK];
   assign modulator_rate_out = adm_osr_t'(mda_q[`ADM_MAB_OS_HI:`ADM_MAB_OS_LO]);
   assign stream_bit_clock_sel_out = mda_q[`ADM_MAB_STREAM] &&
      mda_q[`ADM_MAB_OS_LO];
   assign stream_zero_pattern_out = zfe_q[`ADM_ZEB_DZ_HI:`ADM_ZEB_DZ_LO];
   assign pcm_zero_flag_en_out = zfe_q[`ADM_ZEB_PCM_ZERO_FLAG_EN];
   assign left_zero_pin_out = zf_q[0];
   assign right_zero_pin_out = zf_q[1];
   assign left_data_from_zero_pin_out = mda_q[`ADM_MAB_BYPASS] &&
      ofc_q[`ADM_OFB_BYPASS_STEREO_SELECT];
   assign bipolar_zero_level_out = bpz_q;
endmodule

// *** hw/adm_mute_ramp.sv ***
// soft mute ramp of 256 attenuation steps
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_mute_ramp #(
   parameter int STEPS = `ADM_RAMP_STEPS
) (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic clear_in,
   input wire logic mute_req_in,
   input wire logic step_en_in,
   output logic [7:0] level_out,
   output logic muted_out
);
   import adm_pkg::*;
   localparam logic [7:0] TOP = 8'(STEPS - 1);
   adm_ramp_st_t st_q, st_d;
   logic [7:0] lvl_q, lvl_d;
   always_comb begin
      st_d = st_q;
      lvl_d = lvl_q;
      case (st_q)
         ADM_ST_IDLE: begin
            if (mute_req_in) begin
               st_d = ADM_ST_RAMP;
            end
         end
         ADM_ST_RAMP: begin
            if (step_en_in) begin
               if (mute_req_in && lvl_q != 8'h00) begin
                  lvl_d = lvl_q - 8'h01;
               end else if (!mute_req_in && lvl_q != TOP) begin
                  lvl_d = lvl_q + 8'h01;
               end
            end
            if (mute_req_in && lvl_q == 8'h00) begin
               st_d = ADM_ST_HOLD;
            end else if (!mute_req_in && lvl_q == TOP) begin
               st_d = ADM_ST_IDLE;
            end
         end
         ADM_ST_HOLD: begin
            if (!mute_req_in) begin
               st_d = ADM_ST_RAMP;
            end
         end
         default: begin
            st_d = ADM_ST_IDLE;
            lvl_d = TOP;
         end
      endcase
      if (clear_in) begin
         st_d = ADM_ST_IDLE;
         lvl_d = TOP;
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_q <= ADM_ST_IDLE;
         lvl_q <= 8'hFF;
      end else begin
         st_q <= st_d;
         lvl_q <= lvl_d;
      end
   end
   assign level_out = lvl_q;
   assign muted_out = (st_q == ADM_ST_HOLD);
endmodule

// *** hw/adm_params.svh ***
// constants for the dac mode-control register bank
`ifndef ADM_PARAMS_SVH
`define ADM_PARAMS_SVH
`define ADM_OFS_OUT_FILT 7'h13
`define ADM_OFS_MODE_A 7'h14
`define ADM_OFS_ZF_EN 7'h15
`define ADM_OFS_ZF_STAT 7'h16
`define ADM_OFS_DEV_ID 7'h17
`define ADM_WORD_DIR_BIT 15
`define ADM_ADDR_HI 14
`define ADM_ADDR_LO 8
`define ADM_RST_OUT_FILT 8'h00
`define ADM_RST_MODE_A 8'h00
`define ADM_RST_ZF_EN 8'h01
`define ADM_OFB_ATS_HI 6
`define ADM_OFB_ATS_LO 5
`define ADM_OFB_OPE 4
`define ADM_OFB_BYPASS_STEREO_SELECT 2
`define ADM_OFB_FLT 1
`define ADM_OFB_ZERO_HOLD_MUTE_EN 0
`define ADM_MAB_SOFT_RESET 6
`define ADM_MAB_STREAM 5
`define ADM_MAB_BYPASS 4
`define ADM_MAB_MONO 3
`define ADM_MAB_MONO_CHANNEL_PICK 2
`define ADM_MAB_OS_HI 1
`define ADM_MAB_OS_LO 0
`define ADM_ZEB_DZ_HI 2
`define ADM_ZEB_DZ_LO 1
`define ADM_ZEB_PCM_ZERO_FLAG_EN 0
`define ADM_OUT_FILT_MASK 8'h77
`define ADM_MODE_A_MASK 8'h3F
`define ADM_ZF_EN_MASK 8'h07
`define ADM_RAMP_STEPS 256
`endif

// *** hw/adm_pkg.sv ***
// types for the dac mode-control register bank
package adm_pkg;
   typedef enum logic [1:0] {
      ADM_OSR_64 = 2'h0,
      ADM_OSR_32 = 2'h1,
      ADM_OSR_128 = 2'h2,
      ADM_OSR_RSVD = 2'h3
   } adm_osr_t;
   typedef enum logic [2:0] {
      ADM_ST_IDLE = 3'h1,
      ADM_ST_RAMP = 3'h2,
      ADM_ST_HOLD = 3'h4
   } adm_ramp_st_t;
endpackage

// *** hw/adm_step_div.sv ***
// frame clock divider giving the attenuator step enable
`timescale 1ns/1ps
module adm_step_div (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic frame_tick_in,
   input wire logic [1:0] atten_step_rate_in,
   output logic step_en_out
);
   logic [2:0] cnt_q, cnt_d;
   logic step_d;
   always_comb begin
      cnt_d = cnt_q;
      step_d = 1'b0;
      if (frame_tick_in) begin
         cnt_d = cnt_q + 3'h1;
         // 1, 2, 4 or 8 frames per step
         case (atten_step_rate_in)
            2'h0: step_d = 1'b1;
            2'h1: step_d = cnt_q[0];
            2'h2: step_d = &cnt_q[1:0];
            default: step_d = &cnt_q;
         endcase
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= 3'h0;
         step_en_out <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         step_en_out <= step_d;
      end
   end
endmodule

// *** verif/adm_host.sv ***
// host model driving control words
`timescale 1ns/1ps
module adm_host (
   input wire logic core_clk_in,
   input wire logic read_valid_in,
   input wire logic [7:0] read_data_in,
   output logic word_valid_out,
   output logic [15:0] word_out
);
   initial begin
      word_valid_out = 1'b0;
      word_out = 16'h0000;
   end
   // one word per access, then the word is scrambled
   task xfer(input logic r, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge core_clk_in);
      word_valid_out <= 1'b1;
      word_out <= {r, a, d};
      @(posedge core_clk_in);
      word_valid_out <= 1'b0;
      word_out <= ~{r, a, d};
      #1;
      q = read_valid_in ? read_data_in : 8'hXX;
   endtask
endmodule

// *** verif/adm_mode_regs_chk.sv ***
// assertions on the mode register bank ports
`timescale 1ns/1ps
module adm_mode_regs_chk (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic word_valid_in,
   input wire logic [15:0] word_in,
   input wire logic left_zero_det_in,
   input wire logic read_valid_out,
   input wire logic soft_reset_out,
   input wire logic pcm_zero_flag_en_out,
   input wire logic mono_out,
   input wire logic output_disable_out,
   input wire logic bipolar_zero_level_out,
   input wire logic mono_channel_pick_out,
   input wire logic one_bit_stream_mode_out,
   input wire logic stream_bit_clock_sel_out,
   input wire logic filter_bypass_out,
   input wire logic bypass_stereo_select_out,
   input wire logic left_data_from_zero_pin_out,
   input wire logic left_zero_pin_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic rdw = word_valid_in && word_in[15];
   sequence s_soft_reset_wr;
      word_valid_in && word_in[15:8] == 8'h14 && word_in[6];
   endsequence
   sequence s_zl;
      pcm_zero_flag_en_out && !one_bit_stream_mode_out &&
      !left_data_from_zero_pin_out && !soft_reset_out && left_zero_det_in;
   endsequence
   a_read_reply: assert property (rdw |=> read_valid_out)
      else $error("read without reply");
   a_no_reply: assert property (!rdw |=> !read_valid_out)
      else $error("reply without read");
   a_soft_reset_pulse: assert property
      (s_soft_reset_wr |=> soft_reset_out ##1 !soft_reset_out)
      else $error("soft reset pulse wrong");
   a_soft_reset_clear: assert property
      (soft_reset_out && !word_valid_in |=> pcm_zero_flag_en_out &&
       !mono_out && !output_disable_out)
      else $error("soft reset left state");
   a_ope_bpz: assert property
      (output_disable_out && !soft_reset_out |=> bipolar_zero_level_out)
      else $error("disable without zero level");
   a_pick_mono: assert property
      (mono_channel_pick_out |-> mono_out)
      else $error("channel pick outside mono");
   a_stream_clk: assert property
      (stream_bit_clock_sel_out |-> one_bit_stream_mode_out)
      else $error("bit clock select outside stream");
   a_bypass_pins: assert property
      (left_data_from_zero_pin_out |->
       filter_bypass_out && bypass_stereo_select_out)
      else $error("zero pins carry data wrongly");
   a_flag_pin: assert property (s_zl ##1 s_zl |-> left_zero_pin_out)
      else $error("left zero pin not set");
endmodule
bind adm_mode_regs adm_mode_regs_chk adm_mode_regs_chk_i (
   .core_clk_in, .rst_b_in, .word_valid_in, .word_in, .left_zero_det_in,
   .read_valid_out, .soft_reset_out, .pcm_zero_flag_en_out, .mono_out,
   .output_disable_out, .bipolar_zero_level_out, .mono_channel_pick_out,
   .one_bit_stream_mode_out, .stream_bit_clock_sel_out, .filter_bypass_out,
   .bypass_stereo_select_out, .left_data_from_zero_pin_out,
   .left_zero_pin_out);

// *** verif/tb.sv ***
// testbench for the mode register bank
`timescale 1ns/1ps
module tb;
   logic clk, rst_b, vld, mreq, zl, zr, tick, rv;
   logic [15:0] wd;
   logic [7:0] rdat, q;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   adm_host host_i (.core_clk_in(clk), .read_valid_in(rv),
      .read_data_in(rdat), .word_valid_out(vld), .word_out(wd));
   adm_mode_regs #(.CHIP_ID(5'h0B)) adm_mode_regs_i ( // arbitrary id
      .core_clk_in(clk), .rst_b_in(rst_b), .word_valid_in(vld),
      .word_in(wd), .frame_tick_in(tick), .mute_req_in(mreq),
      .left_zero_det_in(zl), .right_zero_det_in(zr),
      .read_data_out(rdat), .read_valid_out(rv),
      .atten_step_rate_out(), .output_disable_out(),
      .bypass_stereo_select_out(), .rolloff_select_out(),
      .zero_hold_mute_en_out(), .soft_reset_out(),
      .one_bit_stream_mode_out(), .filter_bypass_out(), .mono_out(),
      .mono_channel_pick_out(), .modulator_rate_out(),
      .stream_bit_clock_sel_out(), .stream_zero_pattern_out(),
      .pcm_zero_flag_en_out(), .left_zero_pin_out(),
      .right_zero_pin_out(), .left_data_from_zero_pin_out(),
      .bipolar_zero_level_out(), .soft_mute_level_out());
   task chk(input logic [7:0] g, input logic [7:0] e, input string m);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      host_i.xfer(1'b0, a, d, q);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e);
      host_i.xfer(1'b1, a, 8'h00, q);
      chk(q, e, "read");
   endtask
   task w2;
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= (cyc % 4) == 0;
      if (cyc == 25000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      rst_b = 1'b0;
      mreq = 1'b0;
      zl = 1'b0;
      zr = 1'b0;
      tick = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rd(7'h13, 8'h00);
      rd(7'h14, 8'h00);
      rd(7'h15, 8'h01);
      rd(7'h16, 8'h00);
      rd(7'h17, 8'h0B);
      rd(7'h20, 8'h00);
      $display("reset test done");
      wr(7'h13, 8'hFF);
      wr(7'h14, 8'hBF);
      wr(7'h15, 8'hFF);
      wr(7'h16, 8'hFF);
      wr(7'h17, 8'hFF);
      rd(7'h13, 8'h77);
      rd(7'h14, 8'h3F);
      rd(7'h15, 8'h07);
      rd(7'h16, 8'h00);
      rd(7'h17, 8'h0B);
      chk(8'(adm_mode_regs_i.mono_channel_pick_out), 8'h01, "pk");
      chk(8'(adm_mode_regs_i.stream_bit_clock_sel_out), 8'h01, "bc");
      chk(8'(adm_mode_regs_i.left_data_from_zero_pin_out), 8'h01, "dp");
      chk(8'(adm_mode_regs_i.bipolar_zero_level_out), 8'h01, "bz");
      chk({adm_mode_regs_i.atten_step_rate_out,
         adm_mode_regs_i.rolloff_select_out,
         adm_mode_regs_i.zero_hold_mute_en_out,
         adm_mode_regs_i.filter_bypass_out,
         adm_mode_regs_i.mono_out,
         adm_mode_regs_i.one_bit_stream_mode_out,
         adm_mode_regs_i.output_disable_out}, 8'hFF, "fld");
      chk({5'h00, adm_mode_regs_i.stream_zero_pattern_out,
         adm_mode_regs_i.pcm_zero_flag_en_out}, 8'h07, "zfe");
      chk(8'(adm_mode_regs_i.bypass_stereo_select_out), 8'h01, "ds");
      $display("mask test done");
      for (int r = 0; r < 4; r++) begin
         wr(7'h14, 8'h40);
         chk(8'(adm_mode_regs_i.soft_reset_out), 8'h01, "sr");
         @(posedge clk);
         #1;
         chk(8'(adm_mode_regs_i.soft_reset_out), 8'h00, "sr");
         rd(7'h15, 8'h01);
         chk(adm_mode_regs_i.soft_mute_level_out, 8'hFF, "lv");
         wr(7'h13, {1'b0, r[1:0], 5'h00});
         wr(7'h14, {6'h01, r[1:0]}); // frame rate a quarter of clock
         chk(8'(adm_mode_regs_i.modulator_rate_out), 8'(r), "os");
         chk(8'(adm_mode_regs_i.mono_channel_pick_out), 8'h00, "pk");
         @(posedge clk);
         mreq <= 1'b1;
         n = 0;
         while (adm_mode_regs_i.soft_mute_level_out !== 8'h00 && n < 9000)
         begin
            @(posedge clk);
            n++;
         end
         chk(8'(n >= 254 * (4 << r) && n <= 257 * (4 << r)), 8'h01,
            "ramp");
         mreq <= 1'b0;
      end
      $display("ramp test done");
      wr(7'h14, 8'h40);
      @(posedge clk);
      zl <= 1'b1;
      w2();
      chk(8'(adm_mode_regs_i.left_zero_pin_out), 8'h01, "zl");
      chk(8'(adm_mode_regs_i.right_zero_pin_out), 8'h00, "zr");
      rd(7'h16, 8'h01);
      wr(7'h15, 8'h00);
      w2();
      chk(8'(adm_mode_regs_i.left_zero_pin_out), 8'h00, "pz");
      wr(7'h15, 8'h01);
      wr(7'h13, 8'h01);
      @(posedge clk);
      zr <= 1'b1;
      w2();
      chk(8'(adm_mode_regs_i.bipolar_zero_level_out), 8'h01, "zm");
      wr(7'h14, 8'h20);
      w2();
      chk(8'(adm_mode_regs_i.bipolar_zero_level_out), 8'h00, "st");
      $display("flag test done");
      summarize();
   end
endmodule
